// *** prc_cause_map.sv ***
// maps a drive-side cause onto the additional code low byte
// assumes the cause comes from logic on the same clock
`timescale 1ns/1ps
module prc_cause_map
	import prc_pkg::*;
(
	prc_link_if.mapper link
);
	logic [PRC_BYTE_W-1:0] hit [PRC_CAUSES];
	logic [PRC_BYTE_W-1:0] lo_any;

	// one-hot select over the table, unknown causes fall back
	genvar g;
	generate
		for (g = 0; g < PRC_CAUSES; g++) begin : g_entry
			assign hit[g] = (int'(link.cause) == g) ? PRC_LO_TABLE[g] : PRC_ZERO_BYTE;
		end
	endgenerate

	always_comb begin
		lo_any = PRC_ZERO_BYTE;
		for (int i = 0; i < PRC_CAUSES; i++) begin
			lo_any = lo_any | hit[i];
		end
		if (int'(link.cause) >= PRC_CAUSES) begin
			link.add_lo = PRC_LO_SW_ERROR;
		end else begin
			link.add_lo = lo_any;
		end
	end

endmodule : prc_cause_map

// *** prc_comm_check.sv ***
// tells whether a class from the communication layer is legal there
// assumes the class comes from logic on the same clock
`timescale 1ns/1ps
module prc_comm_check
	import prc_pkg::*;
(
	prc_link_if.class_chk link
);
	// class 8 belongs to the drive, so the comm layer may only use 1..7
	always_comb begin
		link.comm_class_ok = (link.comm_class >= PRC_CLASS_VFD) &&
			(link.comm_class <= PRC_CLASS_OBJ);
	end

endmodule : prc_comm_check

// *** prc_encoder.sv ***
// parameter return code encoder: builds class, code and additional code
// assumes all inputs come from logic on CLOCK; one answer per SVC_DONE
`timescale 1ns/1ps
module prc_encoder
	import prc_pkg::*;
(
	input  wire logic                   CLOCK,
	input  wire logic                   RST_N,
	input  wire logic                   SVC_DONE,
	input  wire logic                   SVC_OK,
	input  wire logic                   COMM_FAULT,
	input  wire logic [PRC_CLASS_W-1:0] COMM_CLASS,
	input  wire logic [PRC_BYTE_W-1:0]  COMM_CODE,
	input  wire logic [PRC_BYTE_W-1:0]  COMM_ADD_HI,
	input  wire logic [PRC_BYTE_W-1:0]  COMM_ADD_LO,
	input  wire prc_pkg::prc_cause_type DRV_CAUSE,
	output logic                        RC_VALID,
	output logic                        RC_ERROR,
	output logic [PRC_BYTE_W-1:0]       RC_CLASS,
	output logic [PRC_BYTE_W-1:0]       RC_CODE,
	output logic [PRC_BYTE_W-1:0]       RC_ADD_HI,
	output logic [PRC_BYTE_W-1:0]       RC_ADD_LO
);
	import prc_pkg::*;

	////////////////////////////////////////////////////////////////////////
	// helpers

	prc_link_if link ();

	assign link.cause = DRV_CAUSE;
	assign link.comm_class = COMM_CLASS;

	prc_cause_map u_map (
		.link (link.mapper)
	);

	prc_comm_check u_chk (
		.link (link.class_chk)
	);

	////////////////////////////////////////////////////////////////////////
	// answer sequencing

	prc_state_type state_reg;
	prc_state_type state_next;

	always_comb begin
		case (state_reg)
			PRC_IDLE: begin
				state_next = SVC_DONE ? PRC_SEND : PRC_IDLE;
			end
			PRC_SEND: begin
				// back to back requests answer in consecutive cycles
				state_next = SVC_DONE ? PRC_SEND : PRC_IDLE;
			end
			default: begin
				state_next = PRC_IDLE;
			end
		endcase
	end

	always_ff @(posedge CLOCK) begin
		if (!RST_N) begin
			state_reg <= PRC_IDLE;
		end else begin
			state_reg <= state_next;
		end
	end

	assign RC_VALID = (state_reg == PRC_SEND);

	////////////////////////////////////////////////////////////////////////
	// return code fields

	logic [PRC_BYTE_W-1:0] class_reg;
	logic [PRC_BYTE_W-1:0] class_next;
	logic [PRC_BYTE_W-1:0] code_reg;
	logic [PRC_BYTE_W-1:0] code_next;
	logic [PRC_BYTE_W-1:0] hi_reg;
	logic [PRC_BYTE_W-1:0] hi_next;
	logic [PRC_BYTE_W-1:0] lo_reg;
	logic [PRC_BYTE_W-1:0] lo_next;
	logic                  error_reg;
	logic                  error_next;

	always_comb begin
		class_next = class_reg;
		code_next  = code_reg;
		hi_next    = hi_reg;
		lo_next    = lo_reg;
		error_next = error_reg;
		if (SVC_DONE) begin
			if (SVC_OK) begin
				class_next = {4'h0, PRC_CLASS_NONE};
				code_next  = PRC_ZERO_BYTE;
				hi_next    = PRC_ZERO_BYTE;
				lo_next    = PRC_ZERO_BYTE;
				error_next = 1'b0;
			end else if (COMM_FAULT && link.comm_class_ok) begin
				// comm layer supplies its own class, code and additional code
				class_next = {4'h0, COMM_CLASS};
				code_next  = COMM_CODE;
				hi_next    = COMM_ADD_HI;
				lo_next    = COMM_ADD_LO;
				error_next = 1'b1;
			end else if (COMM_FAULT) begin
				// a comm fault with a class outside 1..7 is a software fault
				class_next = {4'h0, PRC_CLASS_OTHER};
				code_next  = PRC_CODE_OTHER;
				hi_next    = PRC_ADD_HI_DRV;
				lo_next    = PRC_LO_SW_ERROR;
				error_next = 1'b1;
			end else begin
				class_next = {4'h0, PRC_CLASS_OTHER};
				code_next  = PRC_CODE_OTHER;
				hi_next    = PRC_ADD_HI_DRV;
				lo_next    = link.add_lo;
				error_next = 1'b1;
			end
		end
	end

	always_ff @(posedge CLOCK) begin
		if (!RST_N) begin
			class_reg <= PRC_ZERO_BYTE;
			code_reg  <= PRC_ZERO_BYTE;
			hi_reg    <= PRC_ZERO_BYTE;
			lo_reg    <= PRC_ZERO_BYTE;
			error_reg <= 1'b0;
		end else begin
			class_reg <= class_next;
			code_reg  <= code_next;
			hi_reg    <= hi_next;
			lo_reg    <= lo_next;
			error_reg <= error_next;
		end
	end

	assign RC_CLASS  = class_reg;
	assign RC_CODE   = code_reg;
	assign RC_ADD_HI = hi_reg;
	assign RC_ADD_LO = lo_reg;
	assign RC_ERROR  = error_reg;

	////////////////////////////////////////////////////////////////////////
	// checks

	default clocking cb @(posedge CLOCK); endclocking
	default disable iff (!RST_N);

	sequence s_drive_fail;
		SVC_DONE && !SVC_OK && !COMM_FAULT;
	endsequence

	sequence s_answer;
		RC_VALID && RC_ERROR;
	endsequence

	sequence s_comm_fail;
		SVC_DONE && !SVC_OK && COMM_FAULT;
	endsequence

	property p_answer_follows;
		SVC_DONE |=> RC_VALID;
	endproperty
	a_answer_follows: assert property (p_answer_follows)
		else $error("no answer one cycle after a service");

	property p_no_spurious;
		!SVC_DONE |=> !RC_VALID ##1 (!RC_VALID || $past(SVC_DONE));
	endproperty
	a_no_spurious: assert property (p_no_spurious)
		else $error("answer without a service");

	property p_fields_hold;
		RC_VALID && !SVC_DONE |=> $stable(RC_CLASS) && $stable(RC_ADD_LO);
	endproperty
	a_fields_hold: assert property (p_fields_hold)
		else $error("return code changed without a service");

	// data stand between answers, not only during the valid cycle
	property p_hold_rest;
		!SVC_DONE |=> $stable(RC_CODE) && $stable(RC_ADD_HI) && $stable(RC_ERROR);
	endproperty
	a_hold_rest: assert property (p_hold_rest)
		else $error("return code changed while no service finished");

	property p_class_range;
		s_answer |-> RC_CLASS >= 8'h01 && RC_CLASS <= 8'h08;
	endproperty
	a_class_range: assert property (p_class_range)
		else $error("error class outside 1..8");

	property p_comm_class;
		SVC_DONE && !SVC_OK && COMM_FAULT && COMM_CLASS >= PRC_CLASS_VFD
			&& COMM_CLASS <= PRC_CLASS_OBJ |=> RC_CLASS == {4'h0, $past(COMM_CLASS)};
	endproperty
	a_comm_class: assert property (p_comm_class)
		else $error("comm class not passed through");

	property p_comm_fields;
		s_comm_fail ##0 (COMM_CLASS >= PRC_CLASS_VFD && COMM_CLASS <= PRC_CLASS_OBJ)
			|=> RC_CODE == $past(COMM_CODE) && RC_ADD_HI == $past(COMM_ADD_HI)
			&& RC_ADD_LO == $past(COMM_ADD_LO);
	endproperty
	a_comm_fields: assert property (p_comm_fields)
		else $error("comm code or additional code not passed through");

	// class 8 is reserved for the drive, so a bad comm class becomes a software error
	property p_comm_bad;
		s_comm_fail ##0 (COMM_CLASS < PRC_CLASS_VFD || COMM_CLASS > PRC_CLASS_OBJ)
			|=> RC_CLASS == 8'h08 && RC_CODE == 8'h00 && RC_ADD_LO == 8'h18;
	endproperty
	a_comm_bad: assert property (p_comm_bad)
		else $error("bad comm class not mapped to software error");

	property p_drive_class;
		s_drive_fail |=> s_answer ##0 RC_CLASS == 8'h08;
	endproperty
	a_drive_class: assert property (p_drive_class)
		else $error("drive error not in class 8");

	property p_other_code;
		s_answer ##0 RC_CLASS == 8'h08 |-> RC_CODE == 8'h00;
	endproperty
	a_other_code: assert property (p_other_code)
		else $error("class 8 with nonzero error code");

	property p_drive_hi;
		s_drive_fail |=> RC_ADD_HI == 8'h00 && RC_CLASS == 8'h08;
	endproperty
	a_drive_hi: assert property (p_drive_hi)
		else $error("drive cause with wrong high byte or class");

	property p_lo_index;
		s_drive_fail ##0 DRV_CAUSE == PRC_ILLEGAL_INDEX |=> RC_ADD_LO == 8'h10;
	endproperty
	a_lo_index: assert property (p_lo_index)
		else $error("illegal index not coded 10");

	property p_lo_large;
		s_drive_fail ##0 DRV_CAUSE == PRC_TOO_LARGE |=> RC_ADD_LO == 8'h15;
	endproperty
	a_lo_large: assert property (p_lo_large)
		else $error("too large not coded 15");

	property p_lo_invalid;
		s_drive_fail ##0 DRV_CAUSE == PRC_INVALID_VALUE |=> RC_ADD_LO == 8'h1d;
	endproperty
	a_lo_invalid: assert property (p_lo_invalid)
		else $error("invalid value not coded 1d");

	property p_lo_stage;
		s_drive_fail ##0 DRV_CAUSE == PRC_STAGE_ENABLED |=> RC_ADD_LO == 8'h20;
	endproperty
	a_lo_stage: assert property (p_lo_stage)
		else $error("output stage cause not coded 20");

	property p_lo_diag;
		s_drive_fail ##0 DRV_CAUSE == PRC_DIAG_IF_ONLY |=> RC_ADD_LO == 8'h1a;
	endproperty
	a_lo_diag: assert property (p_lo_diag)
		else $error("diagnostic only not coded 1a");

	property p_lo_saved;
		s_drive_fail ##0 DRV_CAUSE == PRC_NOT_SAVED |=> RC_ADD_LO == 8'h1f;
	endproperty
	a_lo_saved: assert property (p_lo_saved)
		else $error("not saved not coded 1f");

	property p_lo_lock;
		s_drive_fail ##0 DRV_CAUSE == PRC_LOCKED |=> RC_ADD_LO == 8'h13;
	endproperty
	a_lo_lock: assert property (p_lo_lock)
		else $error("parameter lock not coded 13");

	property p_lo_small;
		s_drive_fail ##0 DRV_CAUSE == PRC_TOO_SMALL |=> RC_ADD_LO == 8'h16;
	endproperty
	a_lo_small: assert property (p_lo_small)
		else $error("too small not coded 16");

	property p_lo_option;
		s_drive_fail ##0 DRV_CAUSE == PRC_OPTION_MISSING |=> RC_ADD_LO == 8'h17;
	endproperty
	a_lo_option: assert property (p_lo_option)
		else $error("option missing not coded 17");

	property p_lo_process;
		s_drive_fail ##0 DRV_CAUSE == PRC_PROCESS_IF_ONLY |=> RC_ADD_LO == 8'h19;
	endproperty
	a_lo_process: assert property (p_lo_process)
		else $error("process interface only not coded 19");

	property p_lo_factory;
		s_drive_fail ##0 DRV_CAUSE == PRC_FACTORY_ACTIVE |=> RC_ADD_LO == 8'h14;
	endproperty
	a_lo_factory: assert property (p_lo_factory)
		else $error("factory setting active not coded 14");

	property p_ok_zero;
		SVC_DONE && SVC_OK |=> RC_VALID && !RC_ERROR && RC_CLASS == 8'h00
			&& RC_CODE == 8'h00 && RC_ADD_HI == 8'h00 && RC_ADD_LO == 8'h00;
	endproperty
	a_ok_zero: assert property (p_ok_zero)
		else $error("success did not return all zero");

endmodule : prc_encoder

// *** prc_encoder_tb_top.sv ***
// self-checking bench for the return code encoder
// assumes prc_pkg, prc_link_if and the design modules are compiled first
`timescale 1ns/1ps
module prc_encoder_tb_top;
	import prc_pkg::*;

	logic                   CLOCK = 1'b0;
	logic                   RST_N = 1'b0;
	logic                   SVC_DONE, SVC_OK, COMM_FAULT;
	logic [PRC_CLASS_W-1:0] COMM_CLASS;
	logic [PRC_BYTE_W-1:0]  COMM_CODE, COMM_ADD_HI, COMM_ADD_LO;
	prc_cause_type          DRV_CAUSE;
	logic                   RC_VALID, RC_ERROR;
	logic [PRC_BYTE_W-1:0]  RC_CLASS, RC_CODE, RC_ADD_HI, RC_ADD_LO;
	int                     bad_count = 0;
	int                     samples_checked = 0;
	int                     seed = 32857;
	logic [32:0]            e;
	logic                   pend = 1'b0;
	logic [31:0]            r;

	always #2.5 CLOCK = ~CLOCK;

	prc_master_model master (.svc_done(SVC_DONE), .svc_ok(SVC_OK), .comm_fault(COMM_FAULT),
		.comm_class(COMM_CLASS), .comm_code(COMM_CODE), .comm_add_hi(COMM_ADD_HI),
		.comm_add_lo(COMM_ADD_LO), .drv_cause(DRV_CAUSE));

	prc_encoder dut (.CLOCK(CLOCK), .RST_N(RST_N), .SVC_DONE(SVC_DONE), .SVC_OK(SVC_OK),
		.COMM_FAULT(COMM_FAULT), .COMM_CLASS(COMM_CLASS), .COMM_CODE(COMM_CODE),
		.COMM_ADD_HI(COMM_ADD_HI), .COMM_ADD_LO(COMM_ADD_LO), .DRV_CAUSE(DRV_CAUSE),
		.RC_VALID(RC_VALID), .RC_ERROR(RC_ERROR), .RC_CLASS(RC_CLASS), .RC_CODE(RC_CODE),
		.RC_ADD_HI(RC_ADD_HI), .RC_ADD_LO(RC_ADD_LO));

	////////////////////////////////////////////////////////////////////////////////
	function automatic logic [7:0] lo_of(input logic [4:0] c);
		logic [7:0] t [18];
		t = '{8'h00, 8'h10, 8'h11, 8'h12, 8'h13, 8'h14, 8'h15, 8'h16, 8'h17,
			8'h18, 8'h19, 8'h1a, 8'h1b, 8'h1c, 8'h1d, 8'h1e, 8'h1f, 8'h20};
		return (c < 5'd18) ? t[c] : 8'h18;
	endfunction : lo_of

	// {error, class, code, add high, add low}
	function automatic logic [32:0] model(input logic ok, fault, input logic [3:0] cls,
		input logic [7:0] code, hi, lo, input logic [4:0] cause);
		if (ok) return 33'h0;
		if (fault && cls >= 4'h1 && cls <= 4'h7) return {1'b1, 4'h0, cls, code, hi, lo};
		if (fault) return {1'b1, 8'h08, 8'h00, 8'h00, 8'h18};
		return {1'b1, 8'h08, 8'h00, 8'h00, lo_of(cause)};
	endfunction : model

	task automatic chk(input logic [7:0] seen, exp);
		samples_checked++;
		if (seen !== exp) begin
			bad_count++;
			$display("ERROR %0t mismatch seen %h expected %h", $time, seen, exp);
		end
	endtask : chk

	task automatic check_out();
		chk({7'h0, RC_VALID}, 8'h01);
		chk({7'h0, RC_ERROR}, {7'h0, e[32]});
		chk(RC_CLASS, e[31:24]);
		chk(RC_CODE, e[23:16]);
		chk(RC_ADD_HI, e[15:8]);
		chk(RC_ADD_LO, e[7:0]);
	endtask : check_out

	// a step keeps the request line up, so requests run back to back
	task automatic step(input logic ok, fault, input logic [3:0] cls,
		input logic [7:0] code, hi, lo, input logic [4:0] cause);
		@(negedge CLOCK);
		if (pend) check_out();
		master.put(ok, fault, cls, code, hi, lo, cause);
		e = model(ok, fault, cls, code, hi, lo, cause);
		pend = 1'b1;
	endtask : step

	task automatic idle();
		@(negedge CLOCK);
		if (pend) check_out();
		else begin
			chk({7'h0, RC_VALID}, 8'h00);
			chk(RC_CLASS, e[31:24]);
			chk(RC_ADD_LO, e[7:0]);
		end
		pend = 1'b0;
		master.release_bus();
	endtask : idle

	task automatic end_sim();
		$display("checks %0d mismatches %0d", samples_checked, bad_count);
		if (bad_count == 0 && samples_checked > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask : end_sim

	////////////////////////////////////////////////////////////////////////////////
	initial begin
		repeat (4) @(negedge CLOCK);
		chk({6'h0, RC_VALID, RC_ERROR}, 8'h00);
		chk(RC_CLASS | RC_CODE | RC_ADD_HI | RC_ADD_LO, 8'h00);
		RST_N = 1'b1;
		for (int c = 0; c < 18; c++) step(1'b0, 1'b0, 4'h3, 8'h5a, 8'ha5, 8'h3c, 5'(c));
		step(1'b0, 1'b0, 4'h0, 8'h00, 8'h00, 8'h00, 5'h1f);
		idle();
		idle();
		$display("test drive causes done");
		for (int k = 0; k < 16; k++) step(1'b0, 1'b1, 4'(k), 8'(k * 7), 8'h81, 8'(k), 5'(k));
		step(1'b1, 1'b1, 4'h5, 8'h05, 8'h01, 8'h02, 5'h06);
		idle();
		$display("test comm path and success done");
		for (int n = 0; n < 200; n++) begin
			r = $random(seed);
			if (r[31:29] == 3'h0) idle();
			else step(r[28] & r[27], r[26], r[25:22], r[21:14], r[13:6], r[7:0], 5'(r[4:0] % 18));
		end
		idle();
		idle();
		$display("test random mix done");
		RST_N = 1'b0;
		repeat (2) @(negedge CLOCK);
		chk({6'h0, RC_VALID, RC_ERROR}, 8'h00);
		chk(RC_CLASS | RC_CODE | RC_ADD_HI | RC_ADD_LO, 8'h00);
		RST_N = 1'b1;
		step(1'b0, 1'b0, 4'h0, 8'h00, 8'h00, 8'h00, 5'(PRC_LOCKED));
		idle();
		idle();
		$display("test reset in mid-run done");
		end_sim();
	end

	initial begin
		#(5 * 5000);
		bad_count++;
		end_sim();
	end

endmodule : prc_encoder_tb_top

// *** prc_link_if.sv ***
// carrier between the encoder and its two helpers
// assumes prc_pkg is compiled first
`timescale 1ns/1ps
interface prc_link_if;
	import prc_pkg::*;
	prc_cause_type          cause;
	logic [PRC_BYTE_W-1:0]  add_lo;
	logic [PRC_CLASS_W-1:0] comm_class;
	logic                   comm_class_ok;
	modport mapper (input cause, output add_lo);
	modport class_chk (input comm_class, output comm_class_ok);
	modport user (output cause, output comm_class, input add_lo, input comm_class_ok);
endinterface : prc_link_if

// *** prc_master_model.sv ***
// far-side master model: hands parameter service results to the encoder
// assumes the bench calls its tasks just after a falling edge of the clock
`timescale 1ns/1ps
module prc_master_model
	import prc_pkg::*;
(
	output logic                   svc_done,
	output logic                   svc_ok,
	output logic                   comm_fault,
	output logic [PRC_CLASS_W-1:0] comm_class,
	output logic [PRC_BYTE_W-1:0]  comm_code,
	output logic [PRC_BYTE_W-1:0]  comm_add_hi,
	output logic [PRC_BYTE_W-1:0]  comm_add_lo,
	output prc_pkg::prc_cause_type drv_cause
);
	import prc_pkg::*;

	initial begin
		svc_done = 1'b0;
		svc_ok = 1'b0;
		comm_fault = 1'b0;
		comm_class = 4'h0;
		comm_code = 8'h00;
		comm_add_hi = 8'h00;
		comm_add_lo = 8'h00;
		drv_cause = PRC_NO_ERROR;
	end

	task automatic put(input logic ok, fault, input logic [3:0] cls,
		input logic [7:0] code, hi, lo, input logic [4:0] cause);
		svc_done = 1'b1;
		svc_ok = ok;
		comm_fault = fault;
		comm_class = cls;
		comm_code = code;
		comm_add_hi = hi;
		comm_add_lo = lo;
		drv_cause = prc_cause_type'(cause);
	endtask : put

	// results are not held after the pulse, so show the inverse
	task automatic release_bus();
		svc_done = 1'b0;
		svc_ok = ~svc_ok;
		comm_fault = ~comm_fault;
		comm_class = ~comm_class;
		comm_code = ~comm_code;
		comm_add_hi = ~comm_add_hi;
		comm_add_lo = ~comm_add_lo;
		drv_cause = prc_cause_type'(~drv_cause);
	endtask : release_bus

endmodule : prc_master_model

// *** prc_pkg.sv ***
// constants for the parameter return code encoder
// assumes one system clock; all users import prc_pkg::*
package prc_pkg;

	localparam int unsigned PRC_BYTE_W = 8;
	localparam int unsigned PRC_CLASS_W = 4;
	localparam int unsigned PRC_CAUSE_W = 5;

	// error classes
	localparam logic [PRC_CLASS_W-1:0] PRC_CLASS_NONE  = 4'h0;
	localparam logic [PRC_CLASS_W-1:0] PRC_CLASS_VFD   = 4'h1;
	localparam logic [PRC_CLASS_W-1:0] PRC_CLASS_APP   = 4'h2;
	localparam logic [PRC_CLASS_W-1:0] PRC_CLASS_DEF   = 4'h3;
	localparam logic [PRC_CLASS_W-1:0] PRC_CLASS_RES   = 4'h4;
	localparam logic [PRC_CLASS_W-1:0] PRC_CLASS_SVC   = 4'h5;
	localparam logic [PRC_CLASS_W-1:0] PRC_CLASS_ACC   = 4'h6;
	localparam logic [PRC_CLASS_W-1:0] PRC_CLASS_OBJ   = 4'h7;
	localparam logic [PRC_CLASS_W-1:0] PRC_CLASS_OTHER = 4'h8;

	localparam logic [PRC_BYTE_W-1:0] PRC_ZERO_BYTE  = 8'h00;
	localparam logic [PRC_BYTE_W-1:0] PRC_CODE_OTHER = 8'h00;
	localparam logic [PRC_BYTE_W-1:0] PRC_ADD_HI_DRV = 8'h00;

	// drive-side causes, encoded by position in the table below
	typedef enum logic [PRC_CAUSE_W-1:0] {
		PRC_NO_ERROR, PRC_ILLEGAL_INDEX, PRC_NOT_IMPL, PRC_READ_ONLY,
		PRC_LOCKED, PRC_FACTORY_ACTIVE, PRC_TOO_LARGE, PRC_TOO_SMALL,
		PRC_OPTION_MISSING, PRC_SW_ERROR, PRC_PROCESS_IF_ONLY, PRC_DIAG_IF_ONLY,
		PRC_PROTECTED, PRC_INHIBIT_REQ, PRC_INVALID_VALUE, PRC_FACTORY_DONE,
		PRC_NOT_SAVED, PRC_STAGE_ENABLED
	} prc_cause_type;

	localparam int unsigned PRC_CAUSES = 18;

	// additional code low bytes, index = cause
	localparam logic [PRC_BYTE_W-1:0] PRC_LO_TABLE [PRC_CAUSES] = '{
		8'h00, 8'h10, 8'h11, 8'h12, 8'h13, 8'h14, 8'h15, 8'h16, 8'h17,
		8'h18, 8'h19, 8'h1a, 8'h1b, 8'h1c, 8'h1d, 8'h1e, 8'h1f, 8'h20
	};

	// fallback for causes outside the table
	localparam logic [PRC_BYTE_W-1:0] PRC_LO_SW_ERROR = 8'h18;

	typedef enum logic [1:0] {
		PRC_IDLE = 2'b00,
		PRC_SEND = 2'b01
	} prc_state_type;

endpackage : prc_pkg
